// [shared/pcamc_regs.vh]
`ifndef PCAMC_REGS_VH
`define PCAMC_REGS_VH

// Register addresses on the special-function register port
`define PCAMC_MD_ADDR       8'hd9
`define PCAMC_PWM_ADDR      8'hdf

// counter_mode_control fields
`define PCAMC_MD_IDLE_BIT   7
`define PCAMC_MD_WATCHDOG_ENABLE_BIT_BIT   6
`define PCAMC_MD_LOCK_BIT   5
`define PCAMC_MD_TB_HI      3
`define PCAMC_MD_TB_LO      1
`define PCAMC_MD_ECF_BIT    0
`define PCAMC_MD_RESET      8'h40

// pwm_cycle_configuration fields
`define PCAMC_PWM_RELOAD_VIEW_SELECT_BIT 7
`define PCAMC_PWM_CYCLE_OVERFLOW_IRQ_ENABLE_BIT  6
`define PCAMC_PWM_CYCLE_OVERFLOW_FLAG_BIT  5
`define PCAMC_PWM_CL_HI     1
`define PCAMC_PWM_CL_LO     0
`define PCAMC_PWM_RESET     8'h00

// Timebase encodings
`define PCAMC_TB_DIV12      3'h0
`define PCAMC_TB_DIV4       3'h1
`define PCAMC_TB_T0         3'h2
`define PCAMC_TB_ECI        3'h3
`define PCAMC_TB_SYS        3'h4
`define PCAMC_TB_EXT8       3'h5
`define PCAMC_TB_RTC8       3'h6

// Divider terminal counts (cycles minus one)
`define PCAMC_DIV12_LAST    4'hb
`define PCAMC_DIV4_LAST     2'h3
`define PCAMC_DIV8_LAST     3'h7

// Cycle lengths in bits
`define PCAMC_CYC_BASE      5'h08
`define PCAMC_CYC_16        5'h10

`endif

// [hw/pcamc_sync.v]
`timescale 1ns/1ps
`default_nettype none

module pcamc_sync (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [2:0] d_i,
    output reg  [2:0] q_o
);

    reg [2:0] ff1_q;
    reg [2:0] ff2_q;
    reg [2:0] ff3_q;

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_bit
            always @(posedge clk_i) begin
                if (rst_i) begin
                    ff1_q[i] <= 1'b0;
                    ff2_q[i] <= 1'b0;
                    ff3_q[i] <= 1'b0;
                    q_o[i]   <= 1'b0;
                end else begin
                    ff1_q[i] <= d_i[i];
                    ff2_q[i] <= ff1_q[i];
                    ff3_q[i] <= ff2_q[i];
                    // A level counts only once two stages agree
                    if (ff2_q[i] == ff3_q[i]) begin
                        q_o[i] <= ff3_q[i];
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [hw/pcamc_tick.v]
`timescale 1ns/1ps
`default_nettype none
`include "pcamc_regs.vh"

module pcamc_tick (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [2:0] sel_i,
    input  wire       t0_ovf_i,
    input  wire       eci_i,
    input  wire       ext_i,
    input  wire       rtc_i,
    output reg        tick_o
);

    reg [3:0] div12_q;
    reg [1:0] div4_q;
    reg [2:0] ext_cnt_q;
    reg [2:0] rtc_cnt_q;
    reg       eci_q;
    reg       ext_q;
    reg       rtc_q;
    reg       tick_d;

    wire eci_fall = eci_q & ~eci_i;
    wire ext_rise = ~ext_q & ext_i;
    wire rtc_rise = ~rtc_q & rtc_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            div12_q   <= 4'h0;
            div4_q    <= 2'h0;
            ext_cnt_q <= 3'h0;
            rtc_cnt_q <= 3'h0;
            eci_q     <= 1'b0;
            ext_q     <= 1'b0;
            rtc_q     <= 1'b0;
            tick_o    <= 1'b0;
        end else begin
            div12_q   <= (div12_q == `PCAMC_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
            div4_q    <= div4_q + 2'h1;
            ext_cnt_q <= ext_cnt_q + {2'h0, ext_rise};
            rtc_cnt_q <= rtc_cnt_q + {2'h0, rtc_rise};
            eci_q     <= eci_i;
            ext_q     <= ext_i;
            rtc_q     <= rtc_i;
            tick_o    <= tick_d;
        end
    end

    // Code 111 is reserved and never advances the counter
    always @* begin
        case (sel_i)
            `PCAMC_TB_DIV12: tick_d = (div12_q == `PCAMC_DIV12_LAST);
            `PCAMC_TB_DIV4:  tick_d = (div4_q == `PCAMC_DIV4_LAST);
            `PCAMC_TB_T0:    tick_d = t0_ovf_i;
            `PCAMC_TB_ECI:   tick_d = eci_fall;
            `PCAMC_TB_SYS:   tick_d = 1'b1;
            `PCAMC_TB_EXT8:  tick_d = ext_rise & (ext_cnt_q == `PCAMC_DIV8_LAST);
            `PCAMC_TB_RTC8:  tick_d = rtc_rise & (rtc_cnt_q == `PCAMC_DIV8_LAST);
            default:         tick_d = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// [hw/pcamc_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "pcamc_regs.vh"

module pcamc_top (
    input  wire        CLK_SYS_I,
    input  wire        RST_I,
    input  wire [7:0]  SFR_ADDR_I,
    input  wire [7:0]  SFR_WDATA_I,
    input  wire        SFR_WE_I,
    input  wire        CNT_RUN_I,
    input  wire        IDLE_I,
    input  wire        T0_OVF_I,
    input  wire        ECI_I,
    input  wire        EXT_CLK_I,
    input  wire        RTC_CLK_I,
    input  wire        CF_CLR_I,
    input  wire        WDT_UPD_I,
    input  wire [7:0]  WDT_OFFSET_I,
    input  wire [2:0]  MOD_PWM_I,
    input  wire [2:0]  MOD_PWM16_I,
    output reg  [7:0]  SFR_RDATA_O,
    output reg         IRQ_O,
    output reg         WDT_RESET_O,
    output reg         CF_O,
    output reg  [15:0] COUNTER_O,
    output reg         RELOAD_VIEW_O,
    output reg         WDT_ENABLE_O,
    output reg  [14:0] MOD_CYC_BITS_O,
    output reg  [2:0]  MOD_RELOAD_EN_O
);

    // counter_mode_control state
    reg        idle_suspend_q;
    reg        watchdog_lock_bit_q;
    reg  [2:0] timebase_select_q;
    reg        counter_overflow_irq_enable_q;

    // pwm_cycle_configuration state
    reg        cycle_overflow_irq_enable_q;
    reg        cycle_overflow_flag_q;
    reg  [1:0] cycle_length_select_q;

    reg  [7:0] module_compare_high_q;
    reg        cycle_overflow_flag_d;
    reg [10:0] cycle_mask;
    reg  [7:0] rdata_d;

    wire [2:0] pin_sync;
    wire       tick;

    pcamc_sync u_sync (
        .clk_i (CLK_SYS_I),
        .rst_i (RST_I),
        .d_i   ({RTC_CLK_I, EXT_CLK_I, ECI_I}),
        .q_o   (pin_sync)
    );

    pcamc_tick u_tick (
        .clk_i    (CLK_SYS_I),
        .rst_i    (RST_I),
        .sel_i    (timebase_select_q),
        .t0_ovf_i (T0_OVF_I),
        .eci_i    (pin_sync[0]),
        .ext_i    (pin_sync[1]),
        .rtc_i    (pin_sync[2]),
        .tick_o   (tick)
    );

    wire md_wr  = SFR_WE_I & (SFR_ADDR_I == `PCAMC_MD_ADDR);
    wire pwm_wr = SFR_WE_I & (SFR_ADDR_I == `PCAMC_PWM_ADDR);

    // Run control: the watchdog overrides the software run bit
    wire run = (CNT_RUN_I | WDT_ENABLE_O)
             & ~(idle_suspend_q & IDLE_I);
    wire adv = run & tick;

    wire low_ovf = adv & (COUNTER_O[7:0] == 8'hff);
    wire cnt_ovf = adv & (COUNTER_O == 16'hffff);

    always @* begin
        case (cycle_length_select_q)
            2'h0:    cycle_mask = 11'h0ff;
            2'h1:    cycle_mask = 11'h1ff;
            2'h2:    cycle_mask = 11'h3ff;
            default: cycle_mask = 11'h7ff;
        endcase
    end

    // Overflow of the selected cycle bit happens when all lower bits are ones
    wire cyc_ovf = adv & ((COUNTER_O[10:0] & cycle_mask) == cycle_mask);

    always @* begin
        cycle_overflow_flag_d = cycle_overflow_flag_q;
        if (pwm_wr) begin
            cycle_overflow_flag_d = SFR_WDATA_I[`PCAMC_PWM_CYCLE_OVERFLOW_FLAG_BIT];
        end
        // Hardware set wins over a same-cycle software clear
        if (cyc_ovf) begin
            cycle_overflow_flag_d = 1'b1;
        end
    end

    wire wdt_fire = WDT_ENABLE_O & low_ovf
                  & (COUNTER_O[15:8] == module_compare_high_q);

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            idle_suspend_q                <= 1'b0;
            WDT_ENABLE_O                  <= 1'b1;
            watchdog_lock_bit_q           <= 1'b0;
            timebase_select_q             <= 3'h0;
            counter_overflow_irq_enable_q <= 1'b0;
        end else if (md_wr) begin
            // Frozen while the watchdog runs
            if (!WDT_ENABLE_O) begin
                idle_suspend_q    <= SFR_WDATA_I[`PCAMC_MD_IDLE_BIT];
                timebase_select_q <= SFR_WDATA_I[`PCAMC_MD_TB_HI:`PCAMC_MD_TB_LO];
                counter_overflow_irq_enable_q <= SFR_WDATA_I[`PCAMC_MD_ECF_BIT];
            end
            // Lock only clears through system reset
            watchdog_lock_bit_q <= watchdog_lock_bit_q
                                 | SFR_WDATA_I[`PCAMC_MD_LOCK_BIT];
            // Setting the lock also enables; a locked enable cannot drop
            WDT_ENABLE_O <= SFR_WDATA_I[`PCAMC_MD_WATCHDOG_ENABLE_BIT_BIT]
                          | SFR_WDATA_I[`PCAMC_MD_LOCK_BIT]
                          | watchdog_lock_bit_q;
        end
    end

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            RELOAD_VIEW_O               <= 1'b0;
            cycle_overflow_irq_enable_q <= 1'b0;
            cycle_length_select_q       <= 2'h0;
            cycle_overflow_flag_q       <= 1'b0;
        end else begin
            if (pwm_wr) begin
                RELOAD_VIEW_O               <= SFR_WDATA_I[`PCAMC_PWM_RELOAD_VIEW_SELECT_BIT];
                cycle_overflow_irq_enable_q <= SFR_WDATA_I[`PCAMC_PWM_CYCLE_OVERFLOW_IRQ_ENABLE_BIT];
                cycle_length_select_q <= SFR_WDATA_I[`PCAMC_PWM_CL_HI:`PCAMC_PWM_CL_LO];
            end
            cycle_overflow_flag_q <= cycle_overflow_flag_d;
        end
    end

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            COUNTER_O <= 16'h0000;
        end else if (adv) begin
            COUNTER_O <= COUNTER_O + 16'h0001;
        end
    end

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            CF_O <= 1'b0;
        end else if (cnt_ovf) begin
            CF_O <= 1'b1;
        end else if (CF_CLR_I) begin
            CF_O <= 1'b0;
        end
    end

    // Module 2 compare byte: refreshed to counter high byte plus offset
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            module_compare_high_q <= 8'h00;
        end else if (WDT_UPD_I) begin
            module_compare_high_q <= COUNTER_O[15:8] + WDT_OFFSET_I;
        end
    end

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            WDT_RESET_O <= 1'b0;
            IRQ_O       <= 1'b0;
        end else begin
            WDT_RESET_O <= wdt_fire;
            IRQ_O <= (counter_overflow_irq_enable_q & CF_O)
                   | (cycle_overflow_irq_enable_q & cycle_overflow_flag_q);
        end
    end

    // Per-module effective cycle length and reload use
    genvar m;
    generate
        for (m = 0; m < 3; m = m + 1) begin : g_mod
            always @(posedge CLK_SYS_I) begin
                if (RST_I) begin
                    MOD_CYC_BITS_O[5*m +: 5] <= 5'h00;
                    MOD_RELOAD_EN_O[m]       <= 1'b0;
                end else begin
                    if (!MOD_PWM_I[m]) begin
                        MOD_CYC_BITS_O[5*m +: 5] <= 5'h00;
                    end else if (MOD_PWM16_I[m]) begin
                        MOD_CYC_BITS_O[5*m +: 5] <= `PCAMC_CYC_16;
                    end else begin
                        MOD_CYC_BITS_O[5*m +: 5] <= `PCAMC_CYC_BASE
                                                  + {3'h0, cycle_length_select_q};
                    end
                    MOD_RELOAD_EN_O[m] <= MOD_PWM_I[m] & ~MOD_PWM16_I[m]
                                        & (cycle_length_select_q != 2'h0);
                end
            end
        end
    endgenerate

    always @* begin
        rdata_d = 8'h00;
        if (SFR_ADDR_I == `PCAMC_MD_ADDR) begin
            rdata_d[`PCAMC_MD_IDLE_BIT] = idle_suspend_q;
            rdata_d[`PCAMC_MD_WATCHDOG_ENABLE_BIT_BIT] = WDT_ENABLE_O;
            rdata_d[`PCAMC_MD_LOCK_BIT] = watchdog_lock_bit_q;
            rdata_d[`PCAMC_MD_TB_HI:`PCAMC_MD_TB_LO] = timebase_select_q;
            rdata_d[`PCAMC_MD_ECF_BIT] = counter_overflow_irq_enable_q;
            // Bit 4 stays zero
        end else if (SFR_ADDR_I == `PCAMC_PWM_ADDR) begin
            rdata_d[`PCAMC_PWM_RELOAD_VIEW_SELECT_BIT] = RELOAD_VIEW_O;
            rdata_d[`PCAMC_PWM_CYCLE_OVERFLOW_IRQ_ENABLE_BIT]  = cycle_overflow_irq_enable_q;
            rdata_d[`PCAMC_PWM_CYCLE_OVERFLOW_FLAG_BIT]  = cycle_overflow_flag_q;
            rdata_d[`PCAMC_PWM_CL_HI:`PCAMC_PWM_CL_LO] = cycle_length_select_q;
            // Bits 4 to 2 stay zero
        end
    end

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            SFR_RDATA_O <= 8'h00;
        end else begin
            SFR_RDATA_O <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// [testbench/pcamc_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module pcamc_chk (
    input wire        CLK_SYS_I,
    input wire        RST_I,
    input wire [7:0]  SFR_ADDR_I,
    input wire [7:0]  SFR_WDATA_I,
    input wire        SFR_WE_I,
    input wire        CNT_RUN_I,
    input wire [2:0]  MOD_PWM_I,
    input wire [2:0]  MOD_PWM16_I,
    input wire [7:0]  SFR_RDATA_O,
    input wire        WDT_RESET_O,
    input wire [15:0] COUNTER_O,
    input wire        RELOAD_VIEW_O,
    input wire        WDT_ENABLE_O,
    input wire [14:0] MOD_CYC_BITS_O,
    input wire [2:0]  MOD_RELOAD_EN_O,
    input wire        CF_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    wire wr_md = SFR_WE_I && SFR_ADDR_I == 8'hd9;

    property p_view;
        SFR_WE_I && SFR_ADDR_I == 8'hdf |=> RELOAD_VIEW_O == $past(SFR_WDATA_I[7]);
    endproperty
    a_view: assert property (p_view) else $error("reload view bit wrong");
    property p_wde_on;
        wr_md && SFR_WDATA_I[6] |=> WDT_ENABLE_O;
    endproperty
    a_wde_on: assert property (p_wde_on) else $error("watchdog not enabled");
    // Enable may only come back through a write of enable or lock
    property p_wde_rise;
        $rose(WDT_ENABLE_O) |-> $past(wr_md && (SFR_WDATA_I[6] || SFR_WDATA_I[5]));
    endproperty
    a_wde_rise: assert property (p_wde_rise) else $error("watchdog rose unasked");
    property p_md_rsvd;
        SFR_ADDR_I == 8'hd9 |=> !SFR_RDATA_O[4];
    endproperty
    a_md_rsvd: assert property (p_md_rsvd) else $error("mode bit 4 not zero");
    property p_pwm_rsvd;
        SFR_ADDR_I == 8'hdf |=> SFR_RDATA_O[4:2] == 3'h0;
    endproperty
    a_pwm_rsvd: assert property (p_pwm_rsvd) else $error("pwm bits 4:2 not zero");
    property p_halt;
        (!CNT_RUN_I && !WDT_ENABLE_O) [*2] |-> $stable(COUNTER_O);
    endproperty
    a_halt: assert property (p_halt) else $error("counter ran while stopped");
    property p_p16;
        MOD_PWM_I[0] && MOD_PWM16_I[0] |=> MOD_CYC_BITS_O[4:0] == 5'h10;
    endproperty
    a_p16: assert property (p_p16) else $error("16-bit module length wrong");
    property p_p8;
        MOD_PWM_I[2] && !MOD_PWM16_I[2] |=> MOD_CYC_BITS_O[14:10] inside {[5'h08:5'h0b]};
    endproperty
    a_p8: assert property (p_p8) else $error("pwm module length wrong");
    property p_rld;
        MOD_RELOAD_EN_O[1] |-> MOD_CYC_BITS_O[9:5] inside {[5'h09:5'h0b]};
    endproperty
    a_rld: assert property (p_rld) else $error("reload active out of mode");
    property p_wdr;
        WDT_RESET_O |-> COUNTER_O[7:0] == 8'h00 && $past(WDT_ENABLE_O);
    endproperty
    a_wdr: assert property (p_wdr) else $error("watchdog reset misplaced");
    property p_cf_set;
        COUNTER_O == 16'h0000 && $past(COUNTER_O) == 16'hffff |-> CF_O;
    endproperty
    a_cf_set: assert property (p_cf_set) else $error("overflow flag not set");
    c_wdr: cover property (WDT_RESET_O);
    c_view: cover property (RELOAD_VIEW_O);
    c_rld: cover property (MOD_RELOAD_EN_O[1]);
endmodule

bind pcamc_top pcamc_chk pcamc_chk_inst (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WDATA_I(SFR_WDATA_I), .SFR_WE_I(SFR_WE_I), .CNT_RUN_I(CNT_RUN_I),
    .MOD_PWM_I(MOD_PWM_I), .MOD_PWM16_I(MOD_PWM16_I), .SFR_RDATA_O(SFR_RDATA_O),
    .WDT_RESET_O(WDT_RESET_O), .COUNTER_O(COUNTER_O), .RELOAD_VIEW_O(RELOAD_VIEW_O),
    .WDT_ENABLE_O(WDT_ENABLE_O), .MOD_CYC_BITS_O(MOD_CYC_BITS_O),
    .MOD_RELOAD_EN_O(MOD_RELOAD_EN_O), .CF_O(CF_O));

`default_nettype wire

// [testbench/test_pcamc_top.sv]
`timescale 1ns/1ps
`default_nettype none

module test_pcamc_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        we = 1'b0;
    logic        run = 1'b0;
    logic        idle = 1'b0;
    logic [2:0]  pwm = 3'h7;
    logic [2:0]  pwm16 = 3'h1;
    logic [15:0] cyc = 16'h0000;
    logic [7:0]  rdata;
    logic        irq;
    logic        wdt_rst;
    logic        cf;
    logic        view;
    logic        wde;
    logic [15:0] cnt;
    logic [14:0] cyc_bits;
    logic [2:0]  rld;
    logic [15:0] c0;
    int          n_errors = 0;
    int          checks = 0;
    int          i;
    // Address, write data, expected read back
    logic [23:0] rows [0:8] = '{24'hd90000, 24'hd99f8f, 24'hdfffe3, 24'hdf0000,
        24'hd8ff00, 24'hd94040, 24'hd94f40, 24'hd96060, 24'hd90060};
    // Ticks in 192 cycles per timebase, given the pin patterns driven below
    logic [15:0] tb_exp [0:7] = '{16'h10, 16'h30, 16'h0c, 16'h18, 16'hc0, 16'h06, 16'h03,
        16'h00};

    pcamc_top pcamc_top_inst (
        .CLK_SYS_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata),
        .SFR_WE_I(we), .CNT_RUN_I(run), .IDLE_I(idle), .T0_OVF_I(cyc[3:0] == 4'h0),
        .ECI_I(cyc[2]), .EXT_CLK_I(cyc[1]), .RTC_CLK_I(cyc[2]), .CF_CLR_I(1'b0),
        .WDT_UPD_I(1'b0), .WDT_OFFSET_I(8'h00), .MOD_PWM_I(pwm), .MOD_PWM16_I(pwm16),
        .SFR_RDATA_O(rdata), .IRQ_O(irq), .WDT_RESET_O(wdt_rst), .CF_O(cf),
        .COUNTER_O(cnt), .RELOAD_VIEW_O(view), .WDT_ENABLE_O(wde),
        .MOD_CYC_BITS_O(cyc_bits), .MOD_RELOAD_EN_O(rld));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // Free-running pin patterns feed the T0, ECI, EXT and RTC timebase sources
    always @(posedge clk) begin
        cyc <= #1 cyc + 16'h0001;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Write, then leave the address up so read data shows the result
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        tick(1);
        we = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a);
        addr = a;
        tick(1);
    endtask

    task automatic span(input int n, input logic [15:0] exp, input string what);
        tick(8);
        c0 = cnt;
        tick(n);
        chk(cnt - c0, exp, what);
    endtask

    task automatic reset_dut;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
    endtask

    task automatic wait_low(input logic [7:0] v);
        for (int k = 0; k < 300 && cnt[7:0] !== v; k++) tick(1);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #2300000;
        n_errors++;
        complete_run();
    end

    initial begin
        tick(2);
        rst = 1'b0;
        chk(wde, 1'b1, "enable after reset");
        rd(8'hd9);
        chk(rdata, 8'h40, "mode reset");
        rd(8'hdf);
        chk(rdata, 8'h00, "pwm reset");
        for (i = 0; i < 9; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            chk(rdata, rows[i][7:0], "register row");
        end
        $display("register rows done");
        reset_dut();
        wr(8'hd9, 8'h00);
        chk(rdata, 8'h00, "lock gone after reset");
        run = 1'b1;
        for (i = 0; i < 8; i++) begin
            wr(8'hd9, {4'h0, i[2:0], 1'b0});
            span(192, tb_exp[i], "timebase ticks");
        end
        $display("timebase done");
        wr(8'hd9, 8'h88);
        idle = 1'b1;
        span(20, 16'h0000, "suspended in idle");
        idle = 1'b0;
        span(20, 16'h0014, "running out of idle");
        wr(8'hd9, 8'h08);
        idle = 1'b1;
        span(20, 16'h0014, "running in idle");
        idle = 1'b0;
        $display("idle done");
        run = 1'b0;
        wr(8'hdf, 8'h40);
        chk(rdata, 8'h40, "cycle flag cleared");
        chk(irq, 1'b0, "no request yet");
        run = 1'b1;
        wait_low(8'h80);
        wait_low(8'h01);
        run = 1'b0;
        rd(8'hdf);
        tick(3);
        chk(rdata, 8'h60, "cycle flag at 8-bit wrap");
        chk(irq, 1'b1, "cycle request");
        wr(8'hdf, 8'h00);
        wr(8'hdf, 8'h20);
        tick(2);
        chk(rdata, 8'h20, "cycle flag set by write");
        chk(irq, 1'b0, "cycle request masked");
        $display("cycle flag done");
        for (i = 0; i < 4; i++) begin
            wr(8'hdf, 8'h80 + i[7:0]);
            chk({1'b0, cyc_bits}, {1'b0, 5'h08 + i[4:0], 5'h08 + i[4:0], 5'h10}, "lengths");
            chk({13'h0, rld}, (i == 0) ? 16'h0000 : 16'h0006, "reload enables");
        end
        chk(view, 1'b1, "reload view");
        $display("cycle length done");
        reset_dut();
        // Enable drops first, so the second write may change the frozen bits
        wr(8'hd9, 8'h00);
        wr(8'hd9, 8'h09);
        run = 1'b1;
        for (i = 0; i < 70000 && cf !== 1'b1; i++) tick(1);
        chk(cf, 1'b1, "overflow flag at wrap");
        tick(1);
        chk(irq, 1'b1, "overflow request");
        wr(8'hd9, 8'h08);
        chk(irq, 1'b0, "overflow request masked");
        chk(cf, 1'b1, "overflow flag sticky");
        run = 1'b0;
        $display("overflow done");
        reset_dut();
        for (i = 0; i < 4000 && wdt_rst !== 1'b1; i++) tick(1);
        chk(cnt, 16'h0100, "counter at watchdog reset");
        chk(i > 3000 && i < 3100, 1'b1, "watchdog timeout span");
        $display("watchdog done");
        complete_run();
    end
endmodule

`default_nettype wire
